// *** rtl/sequencer_pkg.sv ***
// Shared constants and carrier types of the system sequencer.
package sequencer_pkg;

  // Serial slave address, seven bits.
  localparam logic [6:0] SLAVE_ADDR = 7'h5A;

  // Register offsets.
  localparam logic [7:0] SYSTEM_CONTROL_OFS = 8'h06;
  localparam logic [7:0] LDO_4_CTRL_OFS = 8'h40;
  localparam logic [7:0] LDO_5_CTRL_OFS = 8'h41;

  // Field positions in system_control.
  localparam int BUTTON_STATE_BIT = 0;
  localparam int BUTTON_IRQ_UNMASK = 1;
  localparam int WRITE_EXACT_BIT = 4;
  // Field position of the on bit in the LDO control registers.
  localparam int LDO_ON_BIT = 7;

  // Reset values.
  localparam logic UNMASK_RESET = 1'h1;
  localparam logic WRITE_EXACT_RESET = 1'h0;
  localparam logic LDO_ON_RESET = 1'h1;

  // Serial byte framing.
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Reset timing.
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int RESET_TIME_MS = 260;
  localparam int RESET_CYCLES_DEFAULT = RESET_TIME_MS * CLK_FREQ_KHZ;
  localparam int RST_CNT_W = 27;

  // Synchronised inputs of the sequencer, in the order they are sampled.
  typedef struct packed {
    logic button_low;
    logic at_ground;
    logic enable_1;
    logic enable_2;
    logic enable_3;
    logic power_good;
    logic in_window;
    logic over_temp;
  } sense_type;

  // Idle levels: button released and not grounded, every flag low.
  localparam sense_type SENSE_IDLE = 8'h80;

  // Rail enables driven to the regulators.
  typedef struct packed {
    logic converter_1;
    logic converter_2;
    logic converter_3;
    logic ldo_4;
    logic ldo_5;
  } rail_en_type;

  // One register write from the serial slave.
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

  // Sequencer states, Gray coded along the startup path.
  typedef enum logic [2:0] {
    SEQ_OFF = 3'h0,
    SEQ_RAMP = 3'h1,
    SEQ_HOLD = 3'h3,
    SEQ_WAIT = 3'h2,
    SEQ_ON = 3'h6
  } seq_state_type;

  // Serial slave phases, Gray coded along the write transaction path.
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_ADDR = 3'h1,
    PH_PTR = 3'h3,
    PH_WDAT = 3'h2,
    PH_RDAT = 3'h6
  } phase_type;

endpackage

// *** rtl/serial_slave.sv ***
// Two-wire serial slave for single-byte register reads and writes.
module serial_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Register side
  output sequencer_pkg::reg_write_type wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic access
);
  import sequencer_pkg::*;

  logic scl_s;
  logic sda_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  phase_type phase_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic nack_reg;

  sync_bits #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_seen = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  wire byte_end = scl_fall & (cnt_reg == LAST_BIT);
  wire ack_end = scl_fall & (cnt_reg == ACK_SLOT);
  wire addr_hit = shift_reg[7:1] == SLAVE_ADDR;

  // A read follows a repeated start, so it uses the stored pointer.
  assign rd_addr = wr.addr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
      phase_reg <= PH_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'h0;
      nack_reg <= 1'h0;
      sda_oe <= 1'h0;
      wr <= '0;
      access <= 1'h0;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      wr.valid <= 1'h0;
      access <= 1'h0;
      if (start_seen) begin
        phase_reg <= PH_ADDR;
        // The clock fall that closes the start wraps the count to zero.
        cnt_reg <= '1;
        sda_oe <= 1'h0;
      end else if (stop_seen) begin
        phase_reg <= PH_IDLE;
        sda_oe <= 1'h0;
      end else if (phase_reg != PH_IDLE) begin
        // Bits are taken on the rising clock edge, MSB first.
        if (scl_rise && cnt_reg < ACK_SLOT) begin
          shift_reg <= {shift_reg[6:0], sda_s};
        end
        if (scl_rise && cnt_reg == ACK_SLOT) begin
          nack_reg <= sda_s;
        end
        if (byte_end) begin
          cnt_reg <= ACK_SLOT;
          unique case (phase_reg)
            PH_ADDR: begin
              // A foreign address leaves the bus alone until the next start.
              if (addr_hit) begin
                sda_oe <= 1'h1;
                rw_reg <= shift_reg[0];
                access <= 1'h1;
              end else begin
                phase_reg <= PH_IDLE;
              end
            end
            PH_PTR: sda_oe <= 1'h1;
            PH_WDAT: begin
              sda_oe <= 1'h1;
              wr.valid <= 1'h1;
              wr.data <= shift_reg;
            end
            PH_RDAT: sda_oe <= 1'h0;
            default: phase_reg <= PH_IDLE;
          endcase
        end else if (ack_end) begin
          cnt_reg <= 4'h0;
          sda_oe <= 1'h0;
          unique case (phase_reg)
            PH_ADDR: begin
              phase_reg <= rw_reg ? PH_RDAT : PH_PTR;
              if (rw_reg) begin
                tx_reg <= rd_data;
                sda_oe <= ~rd_data[7];
              end
            end
            PH_PTR: begin
              phase_reg <= PH_WDAT;
              wr.addr <= shift_reg;
            end
            PH_WDAT: phase_reg <= PH_WDAT;
            PH_RDAT: begin
              // Master nack ends the read; an ack repeats the byte.
              phase_reg <= nack_reg ? PH_IDLE : PH_RDAT;
              tx_reg <= rd_data;
              sda_oe <= ~nack_reg & ~rd_data[7];
            end
            default: phase_reg <= PH_IDLE;
          endcase
        end else if (scl_fall) begin
          cnt_reg <= cnt_reg + 4'h1;
          if (phase_reg == PH_RDAT) begin
            tx_reg <= {tx_reg[6:0], 1'h0};
            sda_oe <= ~tx_reg[6];
          end
        end
      end
    end
  end

endmodule // serial_slave

// *** rtl/sync_bits.sv ***
// Two flip-flop synchroniser for a group of asynchronous levels.
module sync_bits #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sync_bits

// *** rtl/system_sequencer.sv ***
// Push-button power sequencer with reset, interrupt and control register.
//
// Behaviour
// - Answer only slave address 1011010 plus direction.
// - Support single-byte register writes and reads only.
// - Eight bits, MSB first, sampled on rising clock.
// - Receiver acknowledges every byte.
// - Bit 0 reads live push-button state.
// - Bit 1 unmasks the push-button interrupt.
// - Bits 3:2 and 7:5 read-only, writes ignored.
// - Resistor press while off enables converter 1.
// - At 94 percent, enable LDOs, assert reset.
// - Hold reset 260 ms, release if in window.
// - After release, stay up only with enables; here it also stays up while the button is held.
// - After startup, host switches LDOs by register.
// - Enable inputs drive converters 1, 2, 3.
// - System stays on until all enables drop.
// - Grounded button asserts reset until timeout after release.
// - Second press interrupts host, which shuts down.
// - Interrupt on startup or unmasked event until access.
// - Over-temperature disables rails, blocks until cooled.
module system_sequencer #(
  parameter int unsigned RESET_CYCLES =
    sequencer_pkg::RESET_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Push button, resistor press and direct-to-ground detector
  input wire logic push_button_in_low,
  input wire logic button_at_ground,
  // Host enable inputs
  input wire logic enable_input_1,
  input wire logic enable_input_2,
  input wire logic enable_input_3,
  // Analog monitor flags
  input wire logic converter_1_power_good,
  input wire logic converter_1_in_window,
  input wire logic over_temp,
  // Regulator enables
  output sequencer_pkg::rail_en_type rails,
  // Open-drain reset output
  output logic reset_out_low,
  output logic reset_out_low_oe,
  // Open-drain interrupt output
  output logic interrupt_out_low,
  output logic interrupt_out_low_oe
);
  import sequencer_pkg::*;

  localparam logic [RST_CNT_W-1:0] RESET_LAST =
    RST_CNT_W'(RESET_CYCLES - 1);

  sense_type sense;
  reg_write_type wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic access;

  seq_state_type state_reg;
  seq_state_type state_next;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic hard_hold_reg;
  logic button_prev_reg;
  logic unmask_reg;
  logic write_exact_reg;
  logic ldo_4_on_reg;
  logic ldo_5_on_reg;
  logic startup_pend_reg;
  logic button_pend_reg;
  logic reset_oe_reg;
  logic irq_oe_reg;
  logic sda_oe_raw;
  rail_en_type rails_next;
  rail_en_type rails_reg;

  // All pins and analog flags come from outside this clock domain.
  sync_bits #(.WIDTH($bits(sense_type)), .RESET_VAL(SENSE_IDLE)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({push_button_in_low, button_at_ground, enable_input_1,
               enable_input_2, enable_input_3, converter_1_power_good,
               converter_1_in_window, over_temp}),
    .sync_out(sense)
  );

  serial_slave u_slave (
    .clk(clk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe_raw),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .access(access)
  );

  // Register decode, shared by the read mux and the write path.
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    reg_sel = {addr == SYSTEM_CONTROL_OFS, addr == LDO_4_CTRL_OFS,
               addr == LDO_5_CTRL_OFS};
  endfunction

  // Button and enable conditions.
  wire pressed = ~sense.button_low;
  wire hard_press = sense.at_ground;
  wire any_enable = sense.enable_1 | sense.enable_2 | sense.enable_3;
  wire press_edge = pressed & ~button_prev_reg;
  wire timer_done = rst_cnt_reg == RESET_LAST;
  wire [2:0] wr_sel = reg_sel(wr.addr) & {3{wr.valid}};
  wire [2:0] rd_sel = reg_sel(rd_addr);

  // Startup is abandoned if the button goes away before the host
  // has taken over with an enable input.
  wire abandon = ~pressed & ~any_enable;

  // Bits 7:5 and 3:2 have no storage and read as zero.
  wire [7:0] sys_read = {3'h0, write_exact_reg, 2'h0, unmask_reg,
                         pressed};
  wire [7:0] ldo_4_read = {ldo_4_on_reg, 7'h00};
  wire [7:0] ldo_5_read = {ldo_5_on_reg, 7'h00};
  assign rd_data = rd_sel[2] ? sys_read :
                   rd_sel[1] ? ldo_4_read :
                   rd_sel[0] ? ldo_5_read : 8'h00;

  // Sequencer transitions.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SEQ_OFF: begin
        if (pressed && !hard_press && !sense.over_temp) begin
          state_next = SEQ_RAMP;
        end
      end
      SEQ_RAMP: begin
        if (abandon) begin
          state_next = SEQ_OFF;
        end else if (sense.power_good) begin
          state_next = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        // A converter outside its window keeps reset held.
        if (abandon) begin
          state_next = SEQ_OFF;
        end else if (timer_done && sense.in_window) begin
          state_next = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (any_enable) begin
          state_next = SEQ_ON;
        end else if (!pressed) begin
          state_next = SEQ_OFF;
        end
      end
      SEQ_ON: begin
        if (!any_enable) begin
          state_next = SEQ_OFF;
        end
      end
      default: state_next = SEQ_OFF;
    endcase
    // Thermal shutdown overrides every state and blocks startup.
    if (sense.over_temp) begin
      state_next = SEQ_OFF;
    end
  end

  // Rail enables per state.
  always_comb begin
    rails_next = '0;
    unique case (state_next)
      SEQ_OFF: rails_next = '0;
      SEQ_RAMP: rails_next.converter_1 = 1'h1;
      SEQ_HOLD, SEQ_WAIT: begin
        rails_next.converter_1 = 1'h1;
        rails_next.ldo_4 = 1'h1;
        rails_next.ldo_5 = 1'h1;
      end
      SEQ_ON: begin
        rails_next.converter_1 = sense.enable_1;
        rails_next.converter_2 = sense.enable_2;
        rails_next.converter_3 = sense.enable_3;
        rails_next.ldo_4 = ldo_4_on_reg;
        rails_next.ldo_5 = ldo_5_on_reg;
      end
      default: rails_next = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= SEQ_OFF;
      rails_reg <= '0;
      button_prev_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      rails_reg <= rails_next;
      button_prev_reg <= pressed;
    end
  end

  // One timer serves the startup hold and the manual hard reset; both
  // start it from zero, and a grounded button keeps it at zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_cnt_reg <= '0;
      hard_hold_reg <= 1'h0;
    end else if (hard_press) begin
      rst_cnt_reg <= '0;
      hard_hold_reg <= 1'h1;
    end else if (state_reg == SEQ_RAMP && state_next == SEQ_HOLD) begin
      rst_cnt_reg <= '0;
    end else if (state_reg == SEQ_HOLD || hard_hold_reg) begin
      if (!timer_done) begin
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end else begin
        hard_hold_reg <= 1'h0;
      end
    end
  end

  // Control register fields.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      unmask_reg <= UNMASK_RESET;
      write_exact_reg <= WRITE_EXACT_RESET;
      ldo_4_on_reg <= LDO_ON_RESET;
      ldo_5_on_reg <= LDO_ON_RESET;
    end else begin
      if (wr_sel[2]) begin
        unmask_reg <= wr.data[BUTTON_IRQ_UNMASK];
        write_exact_reg <= wr.data[WRITE_EXACT_BIT];
      end
      // Startup turns both LDOs on, so the bits follow what runs.
      if (state_next == SEQ_HOLD) begin
        ldo_4_on_reg <= 1'h1;
        ldo_5_on_reg <= 1'h1;
      end else begin
        if (wr_sel[1]) begin
          ldo_4_on_reg <= wr.data[LDO_ON_BIT];
        end
        if (wr_sel[0]) begin
          ldo_5_on_reg <= wr.data[LDO_ON_BIT];
        end
      end
    end
  end

  // Pending interrupt causes. A new event in the cycle of an access
  // wins over the clear, so no event is lost.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      startup_pend_reg <= 1'h0;
      button_pend_reg <= 1'h0;
    end else begin
      if (state_reg == SEQ_WAIT && state_next == SEQ_ON) begin
        startup_pend_reg <= 1'h1;
      end else if (access || state_next == SEQ_OFF) begin
        startup_pend_reg <= 1'h0;
      end
      if (state_reg == SEQ_ON && press_edge) begin
        button_pend_reg <= 1'h1;
      end else if (access) begin
        button_pend_reg <= 1'h0;
      end
    end
  end

  // Pin drivers, all registered.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reset_oe_reg <= 1'h1;
      irq_oe_reg <= 1'h0;
    end else begin
      reset_oe_reg <= (state_next != SEQ_WAIT && state_next != SEQ_ON) ||
                      hard_press || hard_hold_reg;
      irq_oe_reg <= startup_pend_reg ||
                    (button_pend_reg && unmask_reg);
    end
  end

  // Open-drain pins only ever pull low.
  assign sda_out = 1'h0;
  assign sda_oe = sda_oe_raw;
  assign reset_out_low = 1'h0;
  assign reset_out_low_oe = reset_oe_reg;
  assign interrupt_out_low = 1'h0;
  assign interrupt_out_low_oe = irq_oe_reg;
  assign rails = rails_reg;

endmodule // system_sequencer

// *** tb/host_master.sv ***
// Behavioural host that masters the two-wire serial bus.
module host_master (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // A quarter of the 80 ns bus period.
  task automatic q;
    repeat (5) @(negedge clk);
  endtask
  // The bus clock idles high and only moves inside frames.
  task automatic start;
    sda_oe = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop;
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask
  // Data only moves while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    sda_oe = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r,
                        output logic k);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(1'b1, a);
    k = !a;
  endtask
  // A single-byte write, or a pointer write then a single-byte read.
  task automatic tx(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d, input logic rw,
                    output logic [7:0] r, output logic ok);
    logic [7:0] t;
    logic k;
    r = 8'h00;
    start();
    byte_x({a, 1'b0}, t, ok);
    if (ok) begin
      byte_x(p, t, k);
      ok = ok && k;
      if (rw) begin
        start();
        byte_x({a, 1'b1}, t, k);
        ok = ok && k;
        byte_x(8'hFF, r, k);
      end else begin
        byte_x(d, t, k);
        ok = ok && k;
      end
    end
    stop();
  endtask
endmodule // host_master

// *** tb/system_sequencer_sva.sv ***
// Port-level checker for the system sequencer, bound into the design.
module system_sequencer_sva #(
  parameter int unsigned RESET_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  // Button and enables
  input wire logic push_button_in_low,
  input wire logic button_at_ground,
  input wire logic enable_input_1,
  input wire logic enable_input_2,
  input wire logic enable_input_3,
  // Monitor flags
  input wire logic converter_1_power_good,
  input wire logic converter_1_in_window,
  input wire logic over_temp,
  // Outputs
  input wire sequencer_pkg::rail_en_type rails,
  input wire logic reset_out_low_oe,
  input wire logic interrupt_out_low_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import sequencer_pkg::*;
  // Cycles the reset output has been held so far.
  logic [31:0] held_reg;
  always_ff @(posedge clk) begin
    if (!nrst || !reset_out_low_oe) begin
      held_reg <= 32'h0;
    end else begin
      held_reg <= held_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_start;
    $fell(push_button_in_low) && rails == 5'h00 && !over_temp &&
      !button_at_ground && !converter_1_power_good |->
      ##[2:8] rails == 5'h10;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_ldo;
    $rose(converter_1_power_good) && rails == 5'h10 |->
      ##[2:8] rails == 5'h13 && reset_out_low_oe;
  endproperty
  a_ldo: assert property (p_ldo) else $error("ldo");
  property p_hold;
    $fell(reset_out_low_oe) |->
      held_reg >= RESET_CYCLES && converter_1_in_window;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_shut;
    (push_button_in_low && !enable_input_1 && !enable_input_2 &&
      !enable_input_3) [*8] |-> rails == 5'h00;
  endproperty
  a_shut: assert property (p_shut) else $error("shut");
  property p_conv3;
    (!enable_input_3) [*8] |-> !rails.converter_3;
  endproperty
  a_conv3: assert property (p_conv3) else $error("conv3");
  property p_ground;
    button_at_ground [*6] |-> reset_out_low_oe;
  endproperty
  a_ground: assert property (p_ground) else $error("ground");
  property p_hot;
    over_temp [*6] |-> rails == 5'h00;
  endproperty
  a_hot: assert property (p_hot) else $error("hot");
  property p_irq;
    interrupt_out_low_oe && scl_in && sda_in |=> interrupt_out_low_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_sda;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda: assert property (p_sda) else $error("sda");
endmodule // system_sequencer_sva

bind system_sequencer system_sequencer_sva #(
  .RESET_CYCLES(RESET_CYCLES)
) checker_inst (
  .clk,
  .nrst,
  .scl_in,
  .sda_in,
  .sda_oe,
  .push_button_in_low,
  .button_at_ground,
  .enable_input_1,
  .enable_input_2,
  .enable_input_3,
  .converter_1_power_good,
  .converter_1_in_window,
  .over_temp,
  .rails,
  .reset_out_low_oe,
  .interrupt_out_low_oe
);

// *** tb/tb_top.sv ***
// Self-checking bench for the system sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sequencer_pkg::*;
  // A short reset period keeps the run brief.
  localparam int unsigned RC = 50;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pb_low = 1'b1;
  logic gnd = 1'b0;
  logic en1 = 1'b0;
  logic en2 = 1'b0;
  logic en3 = 1'b0;
  logic pg = 1'b0;
  logic win = 1'b0;
  logic hot = 1'b0;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic rst_oe;
  logic irq_oe;
  logic sda_lvl;
  logic rst_lvl;
  logic irq_lvl;
  rail_en_type rails;
  // Pulled up: low only while some party drives it.
  wire logic sda = !(m_oe || (sda_oe && !sda_lvl));
  int errors = 0;
  int compares = 0;
  logic [7:0] rd;
  logic ok;
  initial begin
    forever #2 clk = !clk;
  end
  system_sequencer #(.RESET_CYCLES(RC)) dut (
    .clk(clk),
    .nrst(nrst),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_lvl),
    .sda_oe(sda_oe),
    .push_button_in_low(pb_low),
    .button_at_ground(gnd),
    .enable_input_1(en1),
    .enable_input_2(en2),
    .enable_input_3(en3),
    .converter_1_power_good(pg),
    .converter_1_in_window(win),
    .over_temp(hot),
    .rails(rails),
    .reset_out_low(rst_lvl),
    .reset_out_low_oe(rst_oe),
    .interrupt_out_low(irq_lvl),
    .interrupt_out_low_oe(irq_oe)
  );
  host_master m (
    .clk(clk),
    .sda(sda),
    .scl(scl),
    .sda_oe(m_oe)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rails_is(input int n, input logic [7:0] e);
    cyc(n);
    chk({3'h0, rails}, e);
  endtask
  task automatic pins_is(input int n, input logic [7:0] e);
    cyc(n);
    // A pin counts as asserted only if its enabled driver pulls low.
    chk({6'h0, rst_oe && !rst_lvl, irq_oe && !irq_lvl}, e);
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    m.tx(SLAVE_ADDR, p, d, 1'b0, rd, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    m.tx(SLAVE_ADDR, p, 8'h00, 1'b1, rd, ok);
    chk({7'h0, ok}, 8'h01);
    chk(rd, e);
  endtask
  task automatic conclude;
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    conclude();
  end
  initial begin
    cyc(8);
    nrst = 1'b1;
    cyc(4);
    rreg(8'h06, 8'h02);
    wreg(8'h06, 8'hEC);
    rreg(8'h06, 8'h00);
    wreg(8'h06, 8'h02);
    rreg(8'h20, 8'h00);
    m.tx(7'h5B, 8'h06, 8'h00, 1'b0, rd, ok);
    chk({7'h0, ok}, 8'h00);
    pb_low = 1'b0;
    rails_is(10, 8'h10);
    pg = 1'b1;
    rails_is(10, 8'h13);
    // Out of the window the reset must outlast its timer.
    pins_is(RC + 20, 8'h02);
    win = 1'b1;
    pins_is(10, 8'h00);
    cyc(40);
    en1 = 1'b1;
    en3 = 1'b1;
    pins_is(10, 8'h01);
    pb_low = 1'b1;
    rails_is(20, 8'h17);
    rreg(8'h06, 8'h02);
    pins_is(0, 8'h00);
    wreg(8'h40, 8'h00);
    rreg(8'h40, 8'h00);
    rreg(8'h41, 8'h80);
    en2 = 1'b1;
    en3 = 1'b0;
    rails_is(10, 8'h19);
    pb_low = 1'b0;
    pins_is(10, 8'h01);
    rreg(8'h06, 8'h03);
    pins_is(0, 8'h00);
    pb_low = 1'b1;
    wreg(8'h06, 8'h00);
    pb_low = 1'b0;
    pins_is(10, 8'h00);
    pb_low = 1'b1;
    wreg(8'h06, 8'h02);
    gnd = 1'b1;
    pins_is(10, 8'h02);
    gnd = 1'b0;
    pins_is(RC - 10, 8'h02);
    pins_is(30, 8'h00);
    en2 = 1'b0;
    rails_is(10, 8'h11);
    en1 = 1'b0;
    rails_is(10, 8'h00);
    pg = 1'b0;
    win = 1'b0;
    hot = 1'b1;
    pb_low = 1'b0;
    rails_is(20, 8'h00);
    hot = 1'b0;
    pb_low = 1'b1;
    cyc(10);
    pb_low = 1'b0;
    rails_is(10, 8'h10);
    hot = 1'b1;
    rails_is(10, 8'h00);
    hot = 1'b0;
    pb_low = 1'b1;
    cyc(10);
    pb_low = 1'b0;
    rails_is(10, 8'h10);
    pb_low = 1'b1;
    rails_is(15, 8'h00);
    conclude();
  end
endmodule // tb_top
